// ---- design/fdsr_ctrl.sv ----
// Drive control: ready detector, stepper seek, track zero, erase and pin timing
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module fdsr_ctrl import fdsr_pkg::*; #(
	parameter int STEP2_T = STEP2_US * 1000 / TICK_NS,
	parameter int OVL_T   = OVL_US * 1000 / TICK_NS,
	parameter int OVD_T   = OVD_US * 1000 / TICK_NS,
	parameter int ERON_T  = ERON_US * 1000 / TICK_NS,
	parameter int EROFF_T = EROFF_US * 1000 / TICK_NS,
	parameter int SPD_T   = SPD_US * 1000 / TICK_NS,
	parameter int TICK_C  = TICK_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        index_sense,
	input  wire logic        motor_on_n,
	input  wire logic        drive_select_n,
	input  wire logic        always_sel,
	input  wire logic        step_n,
	input  wire logic        dir_in,
	input  wire logic        write_gate_n,
	input  wire logic        track0_sense,
	input  wire logic        protect_sense,
	input  wire logic        low_volt,
	input  wire logic        read_raw,
	output fdsr_pins_t       pins,
	output fdsr_coil_t       coil,
	output logic             spindle_en,
	output logic             hi_supply,
	output logic             write_en,
	output logic             erase_gate,
	output logic             erase_gate_probe,
	output logic             phase_b_probe,
	output logic             revolution_probe
);
	logic [6:0]       tick_cnt;
	logic [6:0]       next_tick_cnt;
	logic             tick;
	logic             step_q;
	logic             idx_q;
	logic             rd_q;
	logic             dir_held;
	logic             next_dir;
	fdsr_step_t       st;
	fdsr_step_t       next_st;
	logic [1:0]       cur_pos;
	logic [1:0]       next_pos;
	logic [1:0]       prev_pos;
	logic [1:0]       next_prev;
	logic             step_fall;
	logic             step_rise;
	logic             at_zero;
	logic             int_step1;
	logic             int_step2;
	logic             int_step;
	logic             step2_done;
	logic             ovl_busy;
	logic             ovd_busy;
	logic             speed;
	logic             idx_rise;
	logic [1:0]       idx_cnt;
	logic [1:0]       next_idx_cnt;
	logic             ready;
	logic [TMR_W-1:0] iper_cnt;
	logic [TMR_W-1:0] next_iper_cnt;
	logic [TMR_W-1:0] iper;
	logic [TMR_W-1:0] next_iper;
	logic [3:0]       energ;
	logic             next_wen;
	logic             next_erase;
	logic             ers_trig;
	logic             ers_done;
	logic             rdw_busy;
	fdsr_pins_t       next_pins;
	logic [31:0]      ctrl;
	logic [31:0]      next_ctrl;
	logic [31:0]      next_rdata;
	logic             ack;
	logic             next_ack;
	fdsr_stat_t       stat;
	logic             tunnel;

	assign tunnel    = ctrl[CTRL_TUN];
	assign step_fall = step_q & ~step_n;
	assign step_rise = ~step_q & step_n;
	assign idx_rise  = index_sense & ~idx_q;
	assign ready     = (idx_cnt == 2'h2);
	// Already on track zero and heading out: the step would drive into the stopper
	assign at_zero   = track0_sense & (cur_pos == POS_A) & ~dir_held;
	assign int_step1 = (st == ST_IDLE) & step_rise & ~at_zero & ~low_volt;
	assign int_step2 = (st == ST_GAP) & step2_done;
	assign int_step  = int_step1 | int_step2;
	assign ers_trig  = tunnel & (next_wen != write_en);
	assign tick      = (tick_cnt == 7'(TICK_C - 1));

	// Microsecond tick shared by every delay counter but u_rdw, which counts clock cycles
	always_comb begin
		next_tick_cnt = tick ? 7'h00 : tick_cnt + 7'h01;
	end

	fdsr_timer u_step2 (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (tick),
		.trig    (int_step1),
		.value   (TMR_W'(STEP2_T)),
		.busy    (),
		.done    (step2_done)
	);

	fdsr_timer u_ovl (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (tick),
		.trig    (int_step),
		.value   (TMR_W'(OVL_T)),
		.busy    (ovl_busy),
		.done    ()
	);

	fdsr_timer u_ovd (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (tick),
		.trig    (int_step),
		.value   (TMR_W'(OVD_T)),
		.busy    (ovd_busy),
		.done    ()
	);

	// Retriggered by every index; stays busy while revolutions come within 400 ms
	fdsr_timer u_spd (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (tick),
		.trig    (idx_rise),
		.value   (TMR_W'(SPD_T)),
		.busy    (speed),
		.done    ()
	);

	fdsr_timer u_ers (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (tick),
		.trig    (ers_trig),
		.value   (next_wen ? TMR_W'(ERON_T) : TMR_W'(EROFF_T)),
		.busy    (),
		.done    (ers_done)
	);

	fdsr_timer u_rdw (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (1'b1),
		.trig    (read_raw & ~rd_q & ~write_en),
		.value   (TMR_W'(RDW_CYC)),
		.busy    (rdw_busy),
		.done    ()
	);

	// Seek sequencer: positions A, B, A-bar, B-bar; outward counts up
	always_comb begin
		next_dir  = step_fall ? dir_in : dir_held;
		next_pos  = cur_pos;
		next_prev = prev_pos;
		next_st   = st;
		if (int_step) begin
			next_pos  = dir_held ? cur_pos - 2'h1 : cur_pos + 2'h1;
			next_prev = cur_pos;
		end
		case (st)
			ST_IDLE: if (int_step1) next_st = ST_GAP;
			ST_GAP:  if (step2_done) next_st = ST_IDLE;
			default: next_st = ST_IDLE;
		endcase
	end

	// Old phase overlaps the new one, so B stays on 3.0 + 0.6 ms
	generate
		for (genvar i = 0; i < 4; i++) begin : g_phase
			assign energ[3-i] = (cur_pos == 2'(i)) | (ovl_busy & (prev_pos == 2'(i)));
		end
	endgenerate

	always_comb begin
		next_idx_cnt  = idx_cnt;
		next_iper_cnt = iper_cnt;
		next_iper     = iper;
		if (!speed || low_volt) begin
			next_idx_cnt = 2'h0;
		end else if (idx_rise && !ready) begin
			next_idx_cnt = idx_cnt + 2'h1;
		end
		if (idx_rise) begin
			next_iper     = iper_cnt;
			next_iper_cnt = '0;
		end else if (tick && iper_cnt != '1) begin
			next_iper_cnt = iper_cnt + 1'b1;
		end
	end

	always_comb begin
		next_wen = ~protect_sense & ~write_gate_n
			& (~drive_select_n | always_sel) & ~low_volt;
		if (low_volt) begin
			next_erase = 1'b0;
		end else if (!tunnel) begin
			next_erase = next_wen;
		end else if (ers_done) begin
			next_erase = write_en;
		end else begin
			next_erase = erase_gate;
		end
		next_pins.ready_n         = ~ready;
		next_pins.index_n         = ~index_sense;
		next_pins.track0_n        = ~(track0_sense & coil.a & ~dir_held);
		next_pins.write_protect_n = ~protect_sense;
		next_pins.read_data_n     = ~rdw_busy;
	end

	always_comb begin
		stat.write_en  = write_en;
		stat.erase     = erase_gate;
		stat.hi_supply = hi_supply;
		stat.seek      = (st == ST_GAP) | ovl_busy;
		stat.dir_in    = dir_held;
		stat.ready     = ready;
		stat.speed     = speed;
		stat.coil      = coil;
		next_ack       = (read | write) & ~ack;
		next_ctrl      = ctrl;
		next_rdata     = readdata;
		if (write && ack && address == REG_CTRL) begin
			next_ctrl = {31'h0, writedata[CTRL_TUN]};
		end
		if (read && !ack) begin
			case (address)
				REG_CTRL: next_rdata = ctrl;
				REG_STAT: next_rdata = {{(32 - $bits(stat)){1'b0}}, stat};
				REG_IPER: next_rdata = {{(32 - TMR_W){1'b0}}, iper};
				default:  next_rdata = 32'h0;
			endcase
		end
	end

	assign waitrequest = (read | write) & ~ack;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt         <= 7'h00;
			step_q           <= 1'b1;
			idx_q            <= 1'b0;
			rd_q             <= 1'b0;
			dir_held         <= 1'b0;
			st               <= ST_IDLE;
			cur_pos          <= POS_A;
			prev_pos         <= POS_A;
			idx_cnt          <= 2'h0;
			iper_cnt         <= '0;
			iper             <= '0;
			coil             <= '0;
			hi_supply        <= 1'b0;
			write_en         <= 1'b0;
			erase_gate       <= 1'b0;
			erase_gate_probe <= 1'b0;
			phase_b_probe    <= 1'b0;
			revolution_probe <= 1'b0;
			spindle_en       <= 1'b0;
			pins             <= '1;
			ctrl             <= CTRL_RST;
			readdata         <= 32'h0;
			ack              <= 1'b0;
		end else begin
			tick_cnt         <= next_tick_cnt;
			step_q           <= step_n;
			idx_q            <= index_sense;
			rd_q             <= read_raw;
			dir_held         <= next_dir;
			st               <= next_st;
			cur_pos          <= next_pos;
			prev_pos         <= next_prev;
			idx_cnt          <= next_idx_cnt;
			iper_cnt         <= next_iper_cnt;
			iper             <= next_iper;
			coil             <= fdsr_coil_t'(energ);
			hi_supply        <= ovd_busy;
			write_en         <= next_wen;
			erase_gate       <= next_erase;
			erase_gate_probe <= next_erase;
			phase_b_probe    <= energ[2];
			revolution_probe <= index_sense;
			spindle_en       <= ~motor_on_n & ~low_volt;
			pins             <= next_pins;
			ctrl             <= next_ctrl;
			readdata         <= next_rdata;
			ack              <= next_ack;
		end
	end

	// Checks
	ready_needs_speed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!pins.ready_n |-> $past(speed, 2)) else $error("ready without speed");
	dir_sample_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		step_fall |=> dir_held == $past(dir_in)) else $error("direction not held");
	track_zero_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!pins.track0_n |-> $past(track0_sense && coil.a && !dir_held))
		else $error("track zero gating");
	zero_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st == ST_IDLE && step_rise && at_zero) |=> $stable(cur_pos))
		else $error("outward step at track zero");
	overdrive_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		int_step |=> ##1 hi_supply) else $error("overdrive not started");
	coil_exclusive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!(coil.a && coil.a_n) && !(coil.b && coil.b_n)) else $error("opposite coils on");
	b_only_seek_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(coil.b || coil.b_n) |-> $past(st == ST_GAP || ovl_busy))
		else $error("phase B outside seek");
	rest_on_a_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(st == ST_IDLE && !ovl_busy) |-> cur_pos[0] == 1'b0)
		else $error("rest position not A");
	write_qual_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		write_en |-> $past(!protect_sense && !write_gate_n && (!drive_select_n || always_sel)))
		else $error("write enabled unqualified");
	straddle_erase_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		($past(!tunnel) && !tunnel) |-> erase_gate == write_en)
		else $error("straddle erase lags write");
	second_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		int_step1 |=> st == ST_GAP ##1 st == ST_GAP) else $error("second step missing");
	read_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(read_raw && !rd_q && write_en && !rdw_busy) |=> ##1 pins.read_data_n)
		else $error("read pulse during write");
endmodule

// ---- design/fdsr_pkg.sv ----
// Package for the drive seek, ready and erase control block
// Behaviour
// - Speed detect stays high while the disk turns above half rated speed.
// - Ready latch sets on the second index pulse after speed detect rises.
// - Each step pulse samples and holds the direction input for that step.
// - Step trailing edge makes an internal step; a second follows about 3 ms later.
// - One host step pulse moves the motor two steps, one track.
// - Held direction and internal steps become 1-2 phase drive for four phases.
// - On a phase change two phases are energised together briefly.
// - Even track rests on phase A, odd track on the complementary phase A.
// - Phases B and B-complement are energised only in seeks, about 3.6 ms per step.
// - Phase B is used stepping out from even or in from odd tracks.
// - Each internal step retriggers a 75 ms high-supply overdrive timer.
// - Track-zero output low only with sensor, phase A and outward direction.
// - Erase follows write gate directly, or with on/off delays for tunnel erase.
// - Index pulses come once per revolution, 200 ms apart, 2 to 5.5 ms wide.
// - Read pulses keep their 4, 6 and 8 us spacing for the host decoder.
// - Write-protect output asserts while the disk notch is masked.
// - Motor-on request passes through the spindle gate to the 300 rpm spindle.
// - Outward steps are ignored while the head sits at track zero.
// - Writing needs notch open, write gate, and drive selected or strapped.
package fdsr_pkg;
	localparam int CLK_NS   = 10;
	localparam int TICK_NS  = 1000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int STEP2_US = 3000;
	localparam int PHB_US   = 3600;
	localparam int OVL_US   = PHB_US - STEP2_US;
	localparam int OVD_US   = 75000;
	localparam int ERON_US  = 260;
	localparam int EROFF_US = 900;
	localparam int SPD_US   = 400000;
	localparam int RDW_NS   = 1000;
	localparam int RDW_CYC  = RDW_NS / CLK_NS;
	localparam int TMR_W    = 20;

	localparam logic [3:0]  REG_CTRL   = 4'h0;
	localparam logic [3:0]  REG_STAT   = 4'h4;
	localparam logic [3:0]  REG_IPER   = 4'h8;
	localparam int          CTRL_TUN   = 0;
	localparam logic [31:0] CTRL_RST   = 32'h0;

	localparam logic [1:0]  POS_A  = 2'h0;
	localparam logic [1:0]  POS_B  = 2'h1;
	localparam logic [1:0]  POS_AN = 2'h2;

	typedef struct packed {
		logic a;
		logic b;
		logic a_n;
		logic b_n;
	} fdsr_coil_t;

	typedef struct packed {
		logic ready_n;
		logic index_n;
		logic track0_n;
		logic write_protect_n;
		logic read_data_n;
	} fdsr_pins_t;

	typedef struct packed {
		logic       write_en;
		logic       erase;
		logic       hi_supply;
		logic       seek;
		logic       dir_in;
		logic       ready;
		logic       speed;
		fdsr_coil_t coil;
	} fdsr_stat_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_GAP  = 2'b10
	} fdsr_step_t;
endpackage

// ---- design/fdsr_timer.sv ----
// Retriggerable down-counter with busy level and expiry pulse
`timescale 1ns/100ps
module fdsr_timer import fdsr_pkg::*; #(
	parameter int W = TMR_W
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         tick,
	input  wire logic         trig,
	input  wire logic [W-1:0] value,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_done;

	always_comb begin
		next_cnt  = cnt;
		next_done = 1'b0;
		if (trig) begin
			next_cnt = value;
		end else if (tick && cnt != '0) begin
			next_cnt  = cnt - 1'b1;
			next_done = (cnt == {{(W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt  <= '0;
			done <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			done <= next_done;
		end
	end

	assign busy = (cnt != '0);
endmodule

// ---- verification/fdsr_host_model.sv ----
// Host and disk model: step pulses, index holes and raw read pulses
`timescale 1ns/100ps
module fdsr_host_model import fdsr_pkg::*; #(
	parameter int IDX_PER = 500,
	parameter int IDX_W   = 20
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       step_req,
	input  wire logic       step_in,
	input  wire logic       idx_on,
	input  wire logic       rd_on,
	input  wire logic [1:0] rd_sel,
	output logic            step_n,
	output logic            dir_in,
	output logic            index_sense,
	output logic            read_raw
);
	int st;
	int ix;
	int rc;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= 0;
			ix <= 0;
			rc <= 0;
			step_n <= 1'h1;
			dir_in <= 1'h0;
			index_sense <= 1'h0;
			read_raw <= 1'h0;
		end else begin
			// Direction settles before the fall and holds past the rise
			if (step_req && st == 0) begin
				dir_in <= step_in;
				st <= 6;
			end else if (st != 0) begin
				st <= st - 1;
			end
			step_n <= !(st inside {[2:5]});
			// One hole per revolution, fixed width
			ix <= idx_on ? (ix + 1) % IDX_PER : 0;
			index_sense <= idx_on && ix < IDX_W;
			// Pulses 4, 6 or 8 us apart, as the encoding allows
			if (!rd_on || rc == 0) begin
				rc <= rd_on ? 200 * (2 + rd_sel % 3) - 1 : 0;
			end else begin
				rc <= rc - 1;
			end
			read_raw <= rd_on && rc inside {[1:20]};
		end
	end
endmodule

// ---- verification/floppy_drive_seek_ready_ctrl_bench.sv ----
// Self-checking bench for the drive seek, ready and erase control block
`timescale 1ns/100ps
module floppy_drive_seek_ready_ctrl_bench import fdsr_pkg::*;;
	logic        sys_clk = 1'h0, rst_n = 1'h0, read = 1'h0, write = 1'h0;
	logic [3:0]  address = 4'h0;
	logic [31:0] writedata = 32'h0, readdata, rd;
	logic        waitrequest, motor_on_n = 1'h1, drive_select_n = 1'h1, always_sel = 1'h0;
	logic        write_gate_n = 1'h1, track0_sense = 1'h0, protect_sense = 1'h0, low_volt = 1'h0;
	logic        step_req = 1'h0, step_in = 1'h0, idx_on = 1'h0, rd_on = 1'h0;
	logic [1:0]  rd_sel = 2'h0;
	logic        step_n, dir_in, index_sense, read_raw, spindle_en, hi_supply, write_en;
	logic        erase_gate, saw_b, saw_bn, saw_two, saw_pb, raw_q = 1'h0;
	logic        erase_gate_probe, phase_b_probe, revolution_probe;
	fdsr_pins_t  pins;
	fdsr_coil_t  coil;
	logic [7:0]  seed = 8'h52;
	int          failures = 0, n_compared = 0, lo = 0, n_rd = 0, n_raw = 0, n_wr = 0;
	// Cycles per shortened microsecond tick; erase window bounds in microseconds
	localparam int TCK     = 4;
	localparam int ON_MIN  = 200;
	localparam int ON_MAX  = 320;
	localparam int OFF_MIN = 860;
	localparam int OFF_MAX = 950;

	// Erase delays keep their real counts so the tolerance window itself is checked
	fdsr_ctrl #(.STEP2_T(30), .OVL_T(6), .OVD_T(200), .SPD_T(2000), .TICK_C(TCK)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.index_sense(index_sense), .motor_on_n(motor_on_n), .drive_select_n(drive_select_n),
		.always_sel(always_sel), .step_n(step_n), .dir_in(dir_in),
		.write_gate_n(write_gate_n), .track0_sense(track0_sense),
		.protect_sense(protect_sense), .low_volt(low_volt), .read_raw(read_raw),
		.pins(pins), .coil(coil), .spindle_en(spindle_en), .hi_supply(hi_supply),
		.write_en(write_en), .erase_gate(erase_gate), .erase_gate_probe(erase_gate_probe),
		.phase_b_probe(phase_b_probe), .revolution_probe(revolution_probe));
	fdsr_host_model host (
		.sys_clk(sys_clk), .rst_n(rst_n), .step_req(step_req), .step_in(step_in),
		.idx_on(idx_on), .rd_on(rd_on), .rd_sel(rd_sel), .step_n(step_n), .dir_in(dir_in),
		.index_sense(index_sense), .read_raw(read_raw));

	always #5 sys_clk = ~sys_clk;

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Phase B serves outward from even and inward from odd tracks
	function automatic logic uses_b(input logic inward, input logic odd);
		return inward == odd;
	endfunction
	function automatic logic [31:0] rest(input logic odd);
		return odd ? 32'h8 : 32'h2;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		address <= ad;
		writedata <= wd;
		read <= !wr;
		write <= wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (waitrequest !== 1'h0 && n < 20);
		rd = readdata;
		read <= 1'h0;
		write <= 1'h0;
		if (waitrequest !== 1'h0) begin
			failures++;
			tally_and_finish();
		end
	endtask
	task automatic step(input logic inward);
		@(posedge sys_clk);
		saw_b = 1'h0;
		saw_bn = 1'h0;
		saw_two = 1'h0;
		saw_pb = 1'h0;
		step_req <= 1'h1;
		step_in <= inward;
		tk(1);
		step_req <= 1'h0;
		tk(230);
		@(negedge sys_clk);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	always @(negedge sys_clk) begin
		saw_b = saw_b | coil.b;
		saw_bn = saw_bn | coil.b_n;
		saw_two = saw_two | ($countones(coil) == 2);
		saw_pb = saw_pb | phase_b_probe;
		if (read_raw && !raw_q && !write_en) n_raw++;
		if (read_raw && !raw_q && write_en) n_wr++;
		raw_q = read_raw;
		if (pins.read_data_n === 1'h0) lo++;
		else if (lo > 0) begin
			chk(lo, RDW_CYC, "read pulse width");
			n_rd++;
			lo = 0;
		end
	end

	initial begin
		tk(4);
		rst_n <= 1'h1;
		tk(2);
		@(negedge sys_clk);
		chk(coil, 32'h8, "coil after reset");
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			@(posedge sys_clk);
			protect_sense <= i[0];
			write_gate_n <= !i[1];
			drive_select_n <= !i[2];
			always_sel <= i[3];
			motor_on_n <= seed[0];
			tk(3);
			@(negedge sys_clk);
			chk(write_en, !i[0] && i[1] && (i[2] || i[3]), "write enable");
			chk(erase_gate, !i[0] && i[1] && (i[2] || i[3]), "straddle erase");
			chk(pins.write_protect_n, !i[0], "write protect");
			chk(spindle_en, !seed[0], "spindle gate");
		end
		bus(1'h1, REG_CTRL, 32'h1);
		bus(1'h0, REG_CTRL, 32'h0);
		chk(rd, 32'h1, "control readback");
		bus(1'h1, 4'hC, 32'hFFFF_FFFF);
		bus(1'h0, 4'hC, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		protect_sense <= 1'h0;
		write_gate_n <= 1'h0;
		tk(ON_MIN * TCK);
		@(negedge sys_clk);
		chk(erase_gate, 1'h0, "erase on delay early");
		tk((ON_MAX - ON_MIN) * TCK);
		@(negedge sys_clk);
		chk(erase_gate, 1'h1, "erase on delay late");
		chk(erase_gate_probe, 1'h1, "erase probe on");
		@(posedge sys_clk);
		write_gate_n <= 1'h1;
		tk(OFF_MIN * TCK);
		@(negedge sys_clk);
		chk(erase_gate, 1'h1, "erase off delay early");
		tk((OFF_MAX - OFF_MIN) * TCK);
		@(negedge sys_clk);
		chk(erase_gate, 1'h0, "erase off delay late");
		chk(erase_gate_probe, 1'h0, "erase probe off");
		for (int k = 0; k < 4; k++) begin
			step(k[0] ^ k[1]);
			chk(saw_b, uses_b(k[0] ^ k[1], k[0]), "phase b use");
			chk(saw_pb, uses_b(k[0] ^ k[1], k[0]), "phase b probe");
			chk(saw_bn, !uses_b(k[0] ^ k[1], k[0]), "phase b_n use");
			chk(saw_two, 1'h1, "two phase overlap");
			chk(coil, rest(k[0]), "rest phase after one track");
			chk(hi_supply, 1'h1, "overdrive running");
		end
		bus(1'h0, REG_STAT, 32'h0);
		chk(rd[6:0], 7'h08, "held direction and coil");
		tk(500);
		@(negedge sys_clk);
		chk(hi_supply, 1'h1, "overdrive still running");
		tk(400);
		@(negedge sys_clk);
		chk(hi_supply, 1'h0, "overdrive expired");
		@(posedge sys_clk);
		track0_sense <= 1'h1;
		tk(3);
		@(negedge sys_clk);
		chk(pins.track0_n, 1'h0, "track zero reported");
		step(1'h0);
		chk(coil, 32'h8, "outward step at track zero");
		step(1'h1);
		chk(pins.track0_n, 1'h1, "track zero gated");
		@(posedge sys_clk);
		track0_sense <= 1'h0;
		idx_on <= 1'h1;
		tk(700);
		@(negedge sys_clk);
		chk(pins.ready_n, 1'h1, "not ready after two holes");
		tk(500);
		@(negedge sys_clk);
		chk(pins.ready_n, 1'h0, "ready after third hole");
		for (int n = 0; n < 600 && index_sense !== 1'h1; n++) @(negedge sys_clk);
		if (index_sense !== 1'h1) begin
			failures++;
			tally_and_finish();
		end
		@(negedge sys_clk);
		chk(pins.index_n, 1'h0, "index output");
		chk(revolution_probe, 1'h1, "revolution probe");
		bus(1'h0, REG_STAT, 32'h0);
		chk(rd[5:4], 2'h3, "speed and ready");
		// A hole that lands on a tick edge loses that tick, so one short is allowed
		bus(1'h0, REG_IPER, 32'h0);
		chk((32'(host.IDX_PER / TCK) - rd) <= 32'h1, 1'h1, "index interval");
		low_volt <= 1'h1;
		tk(3);
		@(negedge sys_clk);
		chk(pins.ready_n, 1'h1, "ready cleared at low voltage");
		@(posedge sys_clk);
		low_volt <= 1'h0;
		idx_on <= 1'h0;
		tk(8300);
		bus(1'h0, REG_STAT, 32'h0);
		chk(rd[5:4], 2'h0, "speed lost without holes");
		rd_on <= 1'h1;
		// Writing in the middle blocks must mute the read output
		for (int k = 0; k < 18; k++) begin
			seed = lfsr(seed);
			rd_sel <= seed[1:0];
			write_gate_n <= !(k inside {[8:10]});
			tk(400);
		end
		rd_on <= 1'h0;
		tk(200);
		@(negedge sys_clk);
		chk(n_rd, n_raw, "one read pulse per raw edge");
		chk(n_raw > 6, 1'h1, "read traffic seen");
		chk(n_wr > 0, 1'h1, "raw pulses while writing");
		tally_and_finish();
	end
endmodule
